// ### rtl/gpcm_top.sv
// general-purpose pins, secondary clock mask loader and live insertion gate
//
// Behaviour
// - four general pins, direction and level set by configuration fields.
// - a one in output-enable set bits 3:0 makes that pin a driven output.
// - a one in output-enable clear bits tristates that pin, input only.
// - zero bits in any set or clear field change nothing.
// - after reset all pins are inputs and stored output data is zero.
// - the input field is read-only and returns the live level of all pins.
// - a one in output-data set drives that pin high when it is an output.
// - a one in output-data clear drives that pin low when it is an output.
// - stored output data reaches a pin only while the pin is an output.
// - a 16-bit serial stream on the mask input fills the clock disable mask.
// - shifting starts once primary reset is released with secondary reset asserted.
// - secondary reset stays asserted through shifting and 100 us after it.
// - pins 0 and 2 drive load and shift of the external register.
// - bit pairs 0-7 gate clock outputs 0-3, bits 8-13 outputs 4-9.
// - after shifting pins tristate, mask input is ignored, registers take over.
// - software may rewrite the clock disable mask later.
// - live mode outside hot-swap, pin 3 input and high forces io, memory, master enables off.
// - reads still show written enables; they return when pin 3 falls.
// - halted, queued master work drains but delayed completions are withheld.
// - configuration accesses are still accepted while halted.
// - both mode selects low picks hot-swap; pin 3 becomes the ejector input.
`timescale 1ns/1ps
`default_nettype none
module gpcm_top
  import gpcm_pkg::*;
#(
  parameter int HOLD_CYCLES = SRST_HOLD_CYC
) (
  // clock and primary reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // configuration access
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [15:0]       cfg_wdata,
  output logic      [15:0]       cfg_rdata,
  // general pins
  input  wire logic [PIN_N-1:0]  pin_in,
  output logic      [PIN_N-1:0]  pin_out,
  output logic      [PIN_N-1:0]  pin_oe,
  // clock mask serial input and clock gating
  input  wire logic              clock_mask_serial_in,
  output logic      [SCLK_N-1:0] secondary_clock_output_disable,
  // secondary reset
  input  wire logic              sec_reset_bit,
  output logic                   sec_rst_n,
  // live insertion and command enables {master, memory, io}
  input  wire logic              live_insert_mode,
  input  wire logic [2:0]        cmd_written,
  output logic      [2:0]        cmd_effective,
  output logic                   completion_return_en,
  output logic                   master_drain_en,
  // hot-swap mode
  input  wire logic              mode_select_0,
  input  wire logic              mode_select_1,
  output logic                   hot_swap_mode,
  output logic                   ejector_switch_in_n
);

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);

  gpcm_state_t       state;
  gpcm_state_t       next_state;
  logic [3:0]        od_reg;
  logic [3:0]        next_od;
  logic [3:0]        oe_reg;
  logic [3:0]        next_oe;
  logic [15:0]       mask_reg;
  logic [15:0]       next_mask;
  logic              phase;
  logic              next_phase;
  logic [4:0]        shift_cnt;
  logic [4:0]        next_shift_cnt;
  logic [HW-1:0]     hold_cnt;
  logic [HW-1:0]     next_hold_cnt;
  logic [3:0]        next_pin_out;
  logic [3:0]        next_pin_oe;
  logic [15:0]       next_rdata;
  logic              next_sec_rst_n;
  logic [9:0]        next_clk_dis;
  logic              live_halt;
  logic              hs_mode;
  logic [2:0]        next_cmd;

  // pin control registers and the clock mask
  // per-pin fields, zeros keep
  always_comb begin
    next_od   = od_reg;
    next_oe   = oe_reg;
    next_mask = mask_reg;
    if (cfg_wr) begin
      case (cfg_addr)
        OFS_OD_SET:   next_od = od_reg | cfg_wdata[3:0];
        OFS_OD_CLR:   next_od = od_reg & ~cfg_wdata[3:0];
        OFS_OE_SET:   next_oe = oe_reg | cfg_wdata[3:0];
        OFS_OE_CLR:   next_oe = oe_reg & ~cfg_wdata[3:0];
        OFS_CLK_MASK: next_mask = cfg_wdata;
        default:      next_mask = mask_reg;
      endcase
    end
    // serial bits enter lsb first; the shifter outranks a config write
    if (state == ST_SHIFT && !phase) begin
      next_mask = {clock_mask_serial_in, mask_reg[15:1]};
    end
  end

  // inputs only, zero data after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      od_reg   <= OD_RESET;
      oe_reg   <= OE_RESET;
      mask_reg <= MASK_RESET;
    end else begin
      od_reg   <= next_od;
      oe_reg   <= next_oe;
      mask_reg <= next_mask;
    end
  end

  // mask load sequencer and secondary reset
  always_comb begin
    next_state     = state;
    next_phase     = 1'b0;
    next_shift_cnt = shift_cnt;
    next_hold_cnt  = hold_cnt;
    case (state)
      // the first edge after primary release starts the load
      ST_LOAD: begin
        next_state     = ST_SHIFT;
        next_shift_cnt = 5'h00;
      end
      // sample while shift clock is low, then raise it
      ST_SHIFT: begin
        next_phase = ~phase;
        if (!phase) begin
          next_shift_cnt = shift_cnt + 5'h01;
          if (shift_cnt == SHIFT_LAST) begin
            next_state    = ST_HOLD;
            next_hold_cnt = '0;
          end
        end
      end
      // the hold restarts while software keeps the reset bit set
      ST_HOLD: begin
        if (sec_reset_bit) begin
          next_hold_cnt = '0;
        end else if (hold_cnt == HOLD_LAST) begin
          next_state = ST_RUN;
        end else begin
          next_hold_cnt = hold_cnt + 1'b1;
        end
      end
      ST_RUN: begin
        if (sec_reset_bit) begin
          next_state    = ST_HOLD;
          next_hold_cnt = '0;
        end
      end
      default: next_state = ST_LOAD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state     <= ST_LOAD;
      phase     <= 1'b0;
      shift_cnt <= 5'h00;
      hold_cnt  <= '0;
    end else begin
      state     <= next_state;
      phase     <= next_phase;
      shift_cnt <= next_shift_cnt;
      hold_cnt  <= next_hold_cnt;
    end
  end

  // pins, clock gates, reset and read data
  assign hs_mode   = !mode_select_0 && !mode_select_1;
  // halt only in live mode with pin 3 an input and high
  // hot-swap takes pin 3 away from live insertion
  assign live_halt = live_insert_mode && !hs_mode && !oe_reg[PIN_LIVE] && pin_in[PIN_LIVE];

  always_comb begin
    next_pin_out = 4'h0;
    next_pin_oe  = 4'h0;
    case (next_state)
      // pin 0 low loads the external register
      ST_LOAD: begin
        next_pin_oe = SHIFT_OE;
      end
      // pin 0 high selects shift, pin 2 is the shift clock
      ST_SHIFT: begin
        next_pin_oe             = SHIFT_OE;
        next_pin_out[PIN_LOAD]  = 1'b1;
        next_pin_out[PIN_SHCLK] = next_phase;
      end
      // registers take the pins back once the mask is in
      // stored data shows only where the enable is set
      default: begin
        next_pin_oe  = next_oe;
        next_pin_out = next_od & next_oe;
      end
    endcase
    // released only after the hold and with the reset bit clear
    next_sec_rst_n = (next_state == ST_RUN) && !sec_reset_bit;
    // either bit of a pair gates outputs 0 to 3; bits 14-15 unused
    for (int i = 0; i < 4; i++) begin
      next_clk_dis[i] = next_mask[2*i] | next_mask[2*i+1];
    end
    next_clk_dis[9:4] = next_mask[13:8];
    // reads keep the written enables, the masked copy is separate
    next_cmd = live_halt ? 3'h0 : cmd_written;
    // config reads are never gated by the halt
    next_rdata = 16'h0000;
    if (cfg_rd) begin
      case (cfg_addr)
        OFS_OD_SET, OFS_OD_CLR: next_rdata = {12'h000, od_reg};
        OFS_OE_SET, OFS_OE_CLR: next_rdata = {12'h000, oe_reg};
        // live pin level whatever the direction
        OFS_PIN_IN:             next_rdata = {12'h000, pin_in};
        OFS_CLK_MASK:           next_rdata = mask_reg;
        default:                next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_out                        <= 4'h0;
      pin_oe                         <= 4'h0;
      sec_rst_n                      <= 1'b0;
      secondary_clock_output_disable <= 10'h000;
      cmd_effective                  <= 3'h0;
      completion_return_en           <= 1'b0;
      master_drain_en                <= 1'b0;
      hot_swap_mode                  <= 1'b0;
      ejector_switch_in_n            <= 1'b1;
      cfg_rdata                      <= 16'h0000;
    end else begin
      pin_out                        <= next_pin_out;
      pin_oe                         <= next_pin_oe;
      sec_rst_n                      <= next_sec_rst_n;
      secondary_clock_output_disable <= next_clk_dis;
      // io, memory and master enables forced off
      cmd_effective                  <= next_cmd;
      // completions withheld, queued master work still drains
      completion_return_en           <= !live_halt;
      master_drain_en                <= cmd_written[2];
      // pin 3 serves as the ejector switch in hot-swap mode
      hot_swap_mode                  <= hs_mode;
      ejector_switch_in_n            <= hs_mode ? pin_in[PIN_LIVE] : 1'b1;
      cfg_rdata                      <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // steps of the mask load
  sequence seq_load_go;
    (state == ST_LOAD) && rst_n ##1 (state == ST_SHIFT);
  endsequence
  sequence seq_shift_done;
    ##30 (state == ST_SHIFT) ##1 (state == ST_HOLD);
  endsequence
  sequence seq_sample;
    (state == ST_SHIFT) && !phase;
  endsequence
  // the last sample hands the pins back, so no shift clock rises after it
  sequence seq_mid_sample;
    (state == ST_SHIFT) && !phase && (shift_cnt != SHIFT_LAST);
  endsequence
  sequence seq_clock_high;
    ##1 pin_oe[PIN_SHCLK] && pin_out[PIN_SHCLK] && pin_out[PIN_LOAD];
  endsequence
  sequence seq_shift_exit;
    (state == ST_SHIFT) ##1 (state == ST_HOLD);
  endsequence

  // pin fields and read-back
  AST_RESET_VALUES: assert property (disable iff (1'b0) !rst_n |=> od_reg == 4'h0 && pin_oe == 4'h0)
    else $error("pins or data not cleared by reset");
  AST_OE_SET: assert property (cfg_wr && cfg_addr == OFS_OE_SET
      |=> (oe_reg & $past(cfg_wdata[3:0])) == $past(cfg_wdata[3:0]))
    else $error("enable set bit not applied");
  AST_OE_CLEAR: assert property (cfg_wr && cfg_addr == OFS_OE_CLR
      |=> (oe_reg & $past(cfg_wdata[3:0])) == 4'h0)
    else $error("enable clear bit not applied");
  AST_OD_SET: assert property (cfg_wr && cfg_addr == OFS_OD_SET
      |=> (od_reg & $past(cfg_wdata[3:0])) == $past(cfg_wdata[3:0]))
    else $error("data set bit not applied");
  AST_OD_CLEAR: assert property (cfg_wr && cfg_addr == OFS_OD_CLR
      |=> (od_reg & $past(cfg_wdata[3:0])) == 4'h0)
    else $error("data clear bit not applied");
  AST_ZERO_KEEPS: assert property (cfg_wr && cfg_wdata[3:0] == 4'h0 && cfg_addr != OFS_CLK_MASK
      |=> $stable(od_reg) && $stable(oe_reg))
    else $error("zero write changed pin state");
  AST_PIN_READ: assert property (cfg_rd && cfg_addr == OFS_PIN_IN
      |=> cfg_rdata == {12'h000, $past(pin_in)})
    else $error("pin read not live level");
  AST_PIN_FOLLOWS_REGS: assert property (state == ST_RUN && $past(state) == ST_RUN
      |-> pin_oe == oe_reg && pin_out == (od_reg & oe_reg))
    else $error("pins do not follow registers");

  // mask load and clock gates
  AST_SHIFT_LENGTH: assert property (seq_load_go |-> seq_shift_done)
    else $error("shift phase length wrong");
  AST_SHIFT_PINS: assert property (seq_load_go |-> pin_oe == SHIFT_OE && pin_out == 4'h1)
    else $error("shift control pins wrong after release");
  AST_SHIFT_CLOCK: assert property (seq_mid_sample |-> seq_clock_high)
    else $error("shift clock did not rise after a sample");
  AST_MASK_SAMPLE: assert property (seq_sample |=> mask_reg[15] == $past(clock_mask_serial_in))
    else $error("serial mask bit not taken");
  // a config write may still move the mask, so only idle cycles are watched
  AST_MASK_IGNORED: assert property ((state == ST_HOLD || state == ST_RUN) && !cfg_wr
      |=> $stable(mask_reg))
    else $error("mask moved after shifting");
  AST_PINS_RELEASED: assert property (seq_shift_exit |-> pin_oe == oe_reg)
    else $error("pins not returned to registers");
  AST_MASK_WRITE: assert property (cfg_wr && cfg_addr == OFS_CLK_MASK && !(state == ST_SHIFT && !phase)
      |=> mask_reg == $past(cfg_wdata))
    else $error("mask write not applied");
  AST_CLK_PAIRS: assert property (secondary_clock_output_disable[3:0] ==
      {mask_reg[7] | mask_reg[6], mask_reg[5] | mask_reg[4], mask_reg[3] | mask_reg[2], mask_reg[1] | mask_reg[0]})
    else $error("paired clock gates wrong");
  AST_CLK_SINGLES: assert property (secondary_clock_output_disable[9:4] == mask_reg[13:8])
    else $error("single clock gates wrong");

  // secondary reset
  AST_SRST_HELD: assert property (state != ST_RUN |-> !sec_rst_n)
    else $error("secondary reset released early");
  AST_SRST_BIT: assert property (sec_reset_bit |=> !sec_rst_n)
    else $error("reset bit did not hold secondary reset");
  AST_HOLD_STEP: assert property (state == ST_HOLD && !sec_reset_bit && hold_cnt != HOLD_LAST
      |=> state == ST_HOLD)
    else $error("hold ended early");
  AST_HOLD_END: assert property (state == ST_HOLD && !sec_reset_bit && hold_cnt == HOLD_LAST
      |=> state == ST_RUN && sec_rst_n)
    else $error("secondary reset not released after hold");

  // live insertion and hot-swap
  AST_LIVE_MASK: assert property (live_halt |=> cmd_effective == 3'h0 && !completion_return_en)
    else $error("live halt did not mask enables");
  AST_LIVE_RETURN: assert property (!live_halt |=> cmd_effective == $past(cmd_written))
    else $error("enables did not return");
  AST_LIVE_DRAIN: assert property (live_halt |=> master_drain_en == $past(cmd_written[2]))
    else $error("queued master work stopped by halt");
  AST_CFG_IN_HALT: assert property (live_halt && cfg_rd && cfg_addr == OFS_OE_SET
      |=> cfg_rdata == {12'h000, $past(oe_reg)})
    else $error("config read refused while halted");
  AST_HOT_SWAP: assert property (!mode_select_0 && !mode_select_1
      |=> hot_swap_mode && ejector_switch_in_n == $past(pin_in[PIN_LIVE]))
    else $error("hot-swap mode not selected");
  AST_HS_NO_LIVE: assert property (!mode_select_0 && !mode_select_1
      |=> cmd_effective == $past(cmd_written) && completion_return_en)
    else $error("live halt active in hot-swap mode");
  AST_HS_OFF: assert property (mode_select_0 || mode_select_1 |=> !hot_swap_mode && ejector_switch_in_n)
    else $error("hot-swap mode without both selects low");

endmodule : gpcm_top
`default_nettype wire

// ### common/gpcm_pkg.sv
// constants and types for the general-purpose pin and clock mask block
package gpcm_pkg;
  // configuration index of each field
  localparam logic [7:0] OFS_OD_SET   = 8'h00;
  localparam logic [7:0] OFS_OD_CLR   = 8'h01;
  localparam logic [7:0] OFS_OE_SET   = 8'h02;
  localparam logic [7:0] OFS_OE_CLR   = 8'h03;
  localparam logic [7:0] OFS_PIN_IN   = 8'h04;
  localparam logic [7:0] OFS_CLK_MASK = 8'h06;
  // widths and values after reset
  localparam int         PIN_N        = 4;
  localparam int         MASK_W       = 16;
  localparam int         SCLK_N       = 10;
  localparam logic [3:0] OD_RESET     = 4'h0;
  localparam logic [3:0] OE_RESET     = 4'h0;
  localparam logic [15:0] MASK_RESET  = 16'h0000;
  // pin roles during the mask load, and the live insertion pin
  localparam int         PIN_LOAD     = 0;
  localparam int         PIN_SHCLK    = 2;
  localparam int         PIN_LIVE     = 3;
  localparam logic [3:0] SHIFT_OE     = 4'h5;
  localparam logic [4:0] SHIFT_LAST   = 5'h0F;
  // secondary reset hold after the mask is in
  localparam int         CLK_PERIOD_NS  = 5;
  localparam int         SRST_HOLD_US   = 100;
  localparam int         SRST_HOLD_CYC  = SRST_HOLD_US * 1000 / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_LOAD,
    ST_SHIFT,
    ST_HOLD,
    ST_RUN
  } gpcm_state_t;
endpackage : gpcm_pkg

// ### bench/gpcm_board.sv
// board model: external clock mask shift register and pulled-down general pins
`timescale 1ns/1ps
`default_nettype none
module gpcm_board
  import gpcm_pkg::*;
(
  // pins from the device and the bench
  input  wire logic [PIN_N-1:0]  pin_out,
  input  wire logic [PIN_N-1:0]  pin_oe,
  input  wire logic [PIN_N-1:0]  ext_en,
  input  wire logic [PIN_N-1:0]  ext_val,
  // parallel word presented to the shift register
  input  wire logic [MASK_W-1:0] load_val,
  // resolved pin levels and serial mask
  output logic      [PIN_N-1:0]  pin_lvl,
  output logic                   mask_out
);
  logic [MASK_W-1:0] sreg;
  // undriven pins fall to their pull-downs, so a released pin 0 means load
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val);
  always @(pin_lvl[0] or load_val) if (!pin_lvl[0]) sreg = load_val;
  always @(posedge pin_lvl[2]) if (pin_lvl[0]) sreg = sreg >> 1;
  assign mask_out = sreg[0];
endmodule : gpcm_board
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the general pin and clock mask block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gpcm_pkg::*;
  localparam int HOLD = 8;
  logic              clk, rst_n, cfg_wr, cfg_rd, sec_reset_bit, live, ms0, ms1;
  logic              mask, sec_rst_n, hsm, ej, cre, mde, rd_pend;
  logic [1:0]        a;
  logic [2:0]        cmd_w, cmd_e;
  logic [3:0]        pin_out, pin_oe, pin_lvl, ext_en, ext_val, od, oe;
  logic [7:0]        cfg_addr;
  logic [15:0]       cfg_wdata, cfg_rdata, load_val, d, got, sh;
  logic [SCLK_N-1:0] dis;
  logic [15:0]       exp_q[$];
  int                num_errors, tests_run, n;
  int                seed = 32'hDF2E3522;

  gpcm_top #(.HOLD_CYCLES(HOLD)) i_gpcm_top (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe(pin_oe), .clock_mask_serial_in(mask), .secondary_clock_output_disable(dis),
    .sec_reset_bit(sec_reset_bit), .sec_rst_n(sec_rst_n), .live_insert_mode(live), .cmd_written(cmd_w),
    .cmd_effective(cmd_e), .completion_return_en(cre), .master_drain_en(mde), .mode_select_0(ms0),
    .mode_select_1(ms1), .hot_swap_mode(hsm), .ejector_switch_in_n(ej));
  gpcm_board i_gpcm_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
    .load_val(load_val), .pin_lvl(pin_lvl), .mask_out(mask));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] exp, input logic [15:0] act);
    tests_run++;
    if (act !== exp) begin
      num_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, act);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // one access per two cycles, so no strobe is lowered and raised in one step
  task automatic cfg(input logic rd, input logic [7:0] adr, input logic [15:0] dat);
    cfg_rd = rd;
    cfg_wr = !rd;
    cfg_addr = adr;
    cfg_wdata = dat;
    if (rd) exp_q.push_back(dat);
    tick(1);
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    tick(1);
  endtask : cfg

  task automatic wait_rst(input int lo, input int hi);
    n = 0;
    while (sec_rst_n !== 1'b1 && n < 200) begin
      tick(1);
      n++;
      if (n == 2) sh = {12'h000, pin_oe};
    end
    chk(16'h0001, {15'h0000, n >= lo && n <= hi});
    if (n >= 200) end_sim;
  endtask : wait_rst

  function automatic logic [15:0] dec(input logic [15:0] v);
    dec = 16'h0000;
    for (int i = 0; i < 4; i++) dec[i] = v[2*i] | v[2*i+1];
    for (int i = 4; i < SCLK_N; i++) dec[i] = v[i+4];
  endfunction : dec

  // read data stands one cycle, the cycle after the strobe
  always @(posedge clk) begin
    if (rd_pend && exp_q.size() > 0) begin
      got = cfg_rdata;
      chk(exp_q.pop_front(), got);
    end
    rd_pend = cfg_rd;
  end

  initial begin
    #100000;
    num_errors++;
    end_sim;
  end

  initial begin
    {cfg_wr, cfg_rd, sec_reset_bit, live, ms1, rd_pend, rst_n} = '0;
    ms0 = 1'b1;
    cmd_w = 3'h7;
    cfg_addr = 8'h00;
    cfg_wdata = 16'h0000;
    ext_en = 4'h0;
    ext_val = 4'h0;
    load_val = 16'h0000;
    num_errors = 0;
    tests_run = 0;
    for (int p = 0; p < 3; p++) begin
      load_val = (p == 0) ? 16'($random(seed)) : ((p == 2) ? 16'hFFFF : 16'h0000);
      rst_n = 1'b0;
      tick(4);
      chk(16'h0000, {8'h00, pin_oe, pin_out});
      rst_n = 1'b1;
      wait_rst(HOLD + 30, HOLD + 34);
      chk({12'h000, SHIFT_OE}, sh);
      chk(dec(load_val), {6'h00, dis});
      chk(16'h0000, {12'h000, pin_oe});
      $display("test mask load %0d done", p);
    end
    // the board now feeds zeros, which the block must ignore after shifting
    load_val = 16'h0000;
    od = OD_RESET;
    oe = OE_RESET;
    cfg(1'b1, OFS_OD_SET, 16'h0000);
    repeat (24) begin
      a = 2'($random(seed));
      d = 16'($random(seed));
      cfg(1'b0, {6'h00, a}, d);
      case (a)
        2'h0: od = od | d[3:0];
        2'h1: od = od & ~d[3:0];
        2'h2: oe = oe | d[3:0];
        default: oe = oe & ~d[3:0];
      endcase
      chk({8'h00, oe, od & oe}, {8'h00, pin_oe, pin_out});
      cfg(1'b1, OFS_OD_CLR, {12'h000, od});
      cfg(1'b1, OFS_OE_SET, {12'h000, oe});
    end
    chk(dec(16'hFFFF), {6'h00, dis});
    $display("test pin fields done");
    ext_en = 4'hF;
    ext_val = 4'($random(seed));
    tick(1);
    cfg(1'b1, OFS_PIN_IN, {12'h000, (oe & od) | (~oe & ext_val)});
    cfg(1'b0, OFS_PIN_IN, 16'hFFFF);
    cfg(1'b1, 8'h05, 16'h0000);
    chk({8'h00, oe, od & oe}, {8'h00, pin_oe, pin_out});
    d = 16'($random(seed));
    cfg(1'b0, OFS_CLK_MASK, d);
    cfg(1'b1, OFS_CLK_MASK, d);
    chk(dec(d), {6'h00, dis});
    $display("test readback and mask rewrite done");
    cfg(1'b0, OFS_OE_CLR, 16'h0008);
    oe[3] = 1'b0;
    live = 1'b1;
    ext_val[3] = 1'b1;
    tick(2);
    chk(16'h0001, {10'h000, hsm, cmd_e, cre, mde});
    cfg(1'b1, OFS_OE_SET, {12'h000, oe});
    ext_val[3] = 1'b0;
    tick(2);
    chk(16'h001F, {10'h000, hsm, cmd_e, cre, mde});
    {ms0, ms1} = 2'b00;
    ext_val[3] = 1'b1;
    tick(2);
    chk(16'h001F, {11'h000, hsm, ej, cmd_e});
    ext_val[3] = 1'b0;
    tick(2);
    chk(16'h0017, {11'h000, hsm, ej, cmd_e});
    ms1 = 1'b1;
    tick(2);
    chk(16'h000F, {11'h000, hsm, ej, cmd_e});
    $display("test live insertion and hot-swap done");
    sec_reset_bit = 1'b1;
    tick(2);
    chk(16'h0000, {15'h0000, sec_rst_n});
    sec_reset_bit = 1'b0;
    wait_rst(HOLD - 1, HOLD + 3);
    $display("test secondary reset bit done");
    end_sim;
  end
endmodule : testbench
`default_nettype wire
